/* rtl/iss_top.v */
// Overview of operation
// [R1] clock/data routed to one of two pin pairs
// [R2] bus rate setting 50K, 100K or 400K
// [R3] configurable 7-bit own address, any value
// [R4] enable bit starts and stops slave
// [R5] receive: hold clock low before acknowledge bit
// [R6] transmit: stall after master acknowledge bit
// [R7] stall after start and address byte
// [R8] nak'd address: ignore transaction, no events
// [R9] service releases stall; master may proceed
// [R10] one service handles exactly one event
// [R11] stop service updates status, byte stays pending
// [R12] starts seen only while interrupt enabled
// [R13] polled mode stalls; interrupt mode raises irq
// [R14] control/status register shows transfer status
// [R15] byte event after eighth received bit
// [R16] status write releases stall, drives ack/nak
// [R17] load data then write status to transmit
// [R18] master sends address high, direction in bit0
// [R19] ack address only on own address match
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "iss_consts.vh"
module iss_top (
  input wire core_clk_in,
  input wire nrst_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  input wire scl0_in,
  output reg scl0_out,
  output reg scl0_oe_out,
  input wire sda0_in,
  output reg sda0_out,
  output reg sda0_oe_out,
  input wire scl1_in,
  output reg scl1_out,
  output reg scl1_oe_out,
  input wire sda1_in,
  output reg sda1_out,
  output reg sda1_oe_out,
  output reg irq_out
);
  // fsm states
  localparam S_IDLE = 4'h0;
  localparam S_ADDR = 4'h1;
  localparam S_ASTL = 4'h2;
  localparam S_ACK = 4'h3;
  localparam S_RX = 4'h4;
  localparam S_RSTL = 4'h5;
  localparam S_TX = 4'h6;
  localparam S_TACK = 4'h7;
  localparam S_TSTL = 4'h8;
  localparam S_IGN = 4'h9;
  localparam S_REL = 4'ha;

  // setup count for the selected rate
  function [7:0] tsu_cyc;
    input [1:0] rate;
    begin
      case (rate)
        `ISS_RATE_50K: tsu_cyc = `ISS_TSU_50K_CYC;
        `ISS_RATE_100K: tsu_cyc = `ISS_TSU_100K_CYC;
        default: tsu_cyc = `ISS_TSU_400K_CYC;
      endcase
    end
  endfunction

  reg [`ISS_CFG_W-1:0] cfg_reg; // enable, pin pair, rate, mode, int enable
  reg [6:0] own_addr_reg; // own slave address
  reg [7:0] tx_data_reg; // byte to transmit next
  reg [7:0] rx_data_reg; // last byte received
  reg [`ISS_IRQ_W-1:0] irq_stat_reg; // sticky events
  reg [`ISS_IRQ_W-1:0] irq_mask_reg; // irq gating
  reg [3:0] sync1_reg; // first sync stage, read only by sync2
  reg [3:0] sync2_reg; // second sync stage
  reg scl_d_reg; // delayed selected clock for edges
  reg sda_d_reg; // delayed selected data for edges
  reg [3:0] state_reg; // transfer state
  reg [3:0] rel_tgt_reg; // state entered once the clock is released
  reg [3:0] cnt_reg; // bit counter
  reg [7:0] sr_reg; // shift register
  reg [7:0] tsu_reg; // setup countdown
  reg stall_reg; // hold clock low
  reg sda_low_reg; // pull data low
  reg rw_reg; // direction of this transaction, 1 = read
  reg nak_reg; // ack choice for the pending byte
  reg mack_reg; // master acknowledged last transmitted byte
  reg was_addr_reg; // last serviced byte was an address
  reg stop_pend_reg; // stop waiting for service
  reg err_pend_reg; // error waiting for service
  reg ev_byte_reg; // one-cycle byte event
  reg ev_stop_reg; // one-cycle stop event
  reg ev_err_reg; // one-cycle error event

  wire scl_s; // selected clock after sync
  wire sda_s; // selected data after sync
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire bus_wr;
  wire csr_wr;
  wire byte_pend;
  wire in_xfer;
  wire [`ISS_IRQ_W-1:0] ev_vec;
  wire [7:0] csr_rd;

  // both pairs are synchronised so the mux only ever sees settled levels
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      sync1_reg <= 4'hf;
      sync2_reg <= 4'hf;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      sync1_reg <= {sda1_in, scl1_in, sda0_in, scl0_in};
      sync2_reg <= sync1_reg;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // pin pair choice
  assign scl_s = cfg_reg[`ISS_CFG_PINSEL] ? sync2_reg[2] : sync2_reg[0]; // R1
  assign sda_s = cfg_reg[`ISS_CFG_PINSEL] ? sync2_reg[3] : sync2_reg[1]; // R1
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign bus_wr = wr_in;
  assign csr_wr = bus_wr && (addr_in == `ISS_OFF_CSR); // R16
  assign byte_pend = (state_reg == S_ASTL) || (state_reg == S_RSTL) || (state_reg == S_TSTL);
  assign in_xfer = (state_reg != S_IDLE) && (state_reg != S_IGN);

  // transfer engine
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      state_reg <= S_IDLE;
      rel_tgt_reg <= S_IDLE;
      cnt_reg <= 4'h0;
      sr_reg <= 8'h00;
      tsu_reg <= 8'h00;
      stall_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      rw_reg <= 1'b0;
      nak_reg <= 1'b0;
      mack_reg <= 1'b0;
      was_addr_reg <= 1'b0;
      stop_pend_reg <= 1'b0;
      err_pend_reg <= 1'b0;
      rx_data_reg <= 8'h00;
      ev_byte_reg <= 1'b0;
      ev_stop_reg <= 1'b0;
      ev_err_reg <= 1'b0;
    end else begin
      ev_byte_reg <= 1'b0;
      ev_stop_reg <= 1'b0;
      ev_err_reg <= 1'b0;
      if (!cfg_reg[`ISS_CFG_EN]) begin // R4
        // disabled: let go of the bus at once
        state_reg <= S_IDLE;
        stall_reg <= 1'b0;
        sda_low_reg <= 1'b0;
        stop_pend_reg <= 1'b0;
        err_pend_reg <= 1'b0;
      end else if (start_det && cfg_reg[`ISS_CFG_INTEN]) begin // R12
        // start or repeated start; mid-byte counts as error
        if (in_xfer && cnt_reg != 4'h0) begin
          err_pend_reg <= 1'b1;
          ev_err_reg <= 1'b1;
        end
        state_reg <= S_ADDR;
        cnt_reg <= 4'h0;
        stall_reg <= 1'b0;
        sda_low_reg <= 1'b0;
      end else if (stop_det) begin
        // a stop inside an ignored transaction is silent
        if (in_xfer && state_reg != S_ADDR) begin // R8
          stop_pend_reg <= 1'b1;
          ev_stop_reg <= 1'b1;
        end
        state_reg <= S_IDLE;
        stall_reg <= 1'b0;
        sda_low_reg <= 1'b0;
      end else if (csr_wr && err_pend_reg) begin
        err_pend_reg <= 1'b0; // R10
      end else if (csr_wr && stop_pend_reg) begin
        stop_pend_reg <= 1'b0; // R11
      end else begin
        case (state_reg)
          S_ADDR, S_RX: begin
            if (scl_rise && cnt_reg != 4'h8) begin
              sr_reg <= {sr_reg[6:0], sda_s};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == 4'h8) begin
              if (state_reg == S_RX) begin
                stall_reg <= 1'b1; // R5
                rx_data_reg <= sr_reg;
                was_addr_reg <= 1'b0;
                ev_byte_reg <= 1'b1; // R15
                state_reg <= S_RSTL;
              end else if (sr_reg[7:1] == own_addr_reg) begin // R19
                stall_reg <= 1'b1; // R7
                rw_reg <= sr_reg[0]; // R18
                rx_data_reg <= sr_reg;
                was_addr_reg <= 1'b1;
                ev_byte_reg <= 1'b1;
                state_reg <= S_ASTL;
              end else begin
                state_reg <= S_IGN; // R19
              end
            end
          end
          S_ASTL, S_RSTL: begin
            if (csr_wr) begin // R9
              nak_reg <= wdata_in[`ISS_CSR_NAK];
              sda_low_reg <= ~wdata_in[`ISS_CSR_NAK]; // R16
              tsu_reg <= tsu_cyc(cfg_reg[`ISS_CFG_RATE_HI:`ISS_CFG_RATE_LO]); // R2
              rel_tgt_reg <= S_ACK;
              state_reg <= S_REL;
            end
          end
          S_REL: begin
            // keep data settled for the rate's setup time first
            if (tsu_reg == 8'h00) begin
              stall_reg <= 1'b0; // R9
              state_reg <= rel_tgt_reg;
            end else begin
              tsu_reg <= tsu_reg - 8'h01;
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              cnt_reg <= 4'h0;
              if (nak_reg) begin
                // a refused address drops the transaction; a refused data byte
                // keeps it open so the closing stop is still reported
                sda_low_reg <= 1'b0;
                state_reg <= was_addr_reg ? S_IGN : S_RX; // R8
              end else if (rw_reg) begin
                sr_reg <= tx_data_reg; // R17
                sda_low_reg <= ~tx_data_reg[7];
                state_reg <= S_TX;
              end else begin
                sda_low_reg <= 1'b0;
                state_reg <= S_RX;
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (cnt_reg == 4'h7) begin
                sda_low_reg <= 1'b0;
                state_reg <= S_TACK;
              end else begin
                sda_low_reg <= ~sr_reg[6];
                sr_reg <= {sr_reg[6:0], 1'b0};
                cnt_reg <= cnt_reg + 4'h1;
              end
            end
          end
          S_TACK: begin
            if (scl_rise) begin
              mack_reg <= ~sda_s;
            end else if (scl_fall) begin
              stall_reg <= 1'b1; // R6
              was_addr_reg <= 1'b0;
              ev_byte_reg <= 1'b1;
              state_reg <= S_TSTL;
            end
          end
          S_TSTL: begin
            if (csr_wr) begin
              if (!mack_reg) begin
                // master is done reading: free the bus and wait
                stall_reg <= 1'b0;
                state_reg <= S_IGN;
              end else begin
                sr_reg <= tx_data_reg; // R17
                sda_low_reg <= ~tx_data_reg[7];
                cnt_reg <= 4'h0;
                tsu_reg <= tsu_cyc(cfg_reg[`ISS_CFG_RATE_HI:`ISS_CFG_RATE_LO]);
                rel_tgt_reg <= S_TX;
                state_reg <= S_REL;
              end
            end
          end
          default: begin
            // idle and ignored transactions wait for a start
            stall_reg <= 1'b0;
            sda_low_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // byte events reach the irq only in interrupt mode; polled mode just stalls
  assign ev_vec = {ev_err_reg, ev_stop_reg,
                   ev_byte_reg & ~cfg_reg[`ISS_CFG_POLLED]}; // R13
  assign csr_rd = {1'b0, state_reg != S_IDLE, err_pend_reg, stop_pend_reg,
                   mack_reg, was_addr_reg, rw_reg, byte_pend}; // R14

  // register writes
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      cfg_reg <= `ISS_CFG_RST;
      own_addr_reg <= `ISS_ADDR_RST;
      tx_data_reg <= 8'h00;
      irq_mask_reg <= `ISS_MASK_RST;
    end else if (bus_wr) begin
      case (addr_in)
        `ISS_OFF_CFG: cfg_reg <= wdata_in[`ISS_CFG_W-1:0]; // R4
        `ISS_OFF_ADDR: own_addr_reg <= wdata_in[6:0]; // R3
        `ISS_OFF_DATA: tx_data_reg <= wdata_in; // R17
        `ISS_OFF_IRQ_MASK: irq_mask_reg <= wdata_in[`ISS_IRQ_W-1:0];
        default: begin
          // other offsets take no write
        end
      endcase
    end
  end

  // reads, sticky irq status with read-to-clear; a new event beats the clear
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      rdata_out <= 8'h00;
      irq_stat_reg <= {`ISS_IRQ_W{1'b0}};
      irq_out <= 1'b0;
    end else begin
      if (rd_in && addr_in == `ISS_OFF_IRQ_STAT) begin
        irq_stat_reg <= ev_vec;
      end else begin
        irq_stat_reg <= irq_stat_reg | ev_vec;
      end
      irq_out <= |(irq_stat_reg & irq_mask_reg);
      if (rd_in) begin
        case (addr_in)
          `ISS_OFF_CFG: rdata_out <= {2'h0, cfg_reg};
          `ISS_OFF_ADDR: rdata_out <= {1'b0, own_addr_reg};
          `ISS_OFF_CSR: rdata_out <= csr_rd; // R14
          `ISS_OFF_DATA: rdata_out <= rx_data_reg;
          `ISS_OFF_IRQ_STAT: rdata_out <= {5'h00, irq_stat_reg};
          `ISS_OFF_IRQ_MASK: rdata_out <= {5'h00, irq_mask_reg};
          default: rdata_out <= 8'h00;
        endcase
      end else begin
        rdata_out <= 8'h00;
      end
    end
  end

  // open-drain drivers: data out is always low, only the enables move
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      scl0_out <= 1'b0;
      sda0_out <= 1'b0;
      scl1_out <= 1'b0;
      sda1_out <= 1'b0;
      scl0_oe_out <= 1'b0;
      sda0_oe_out <= 1'b0;
      scl1_oe_out <= 1'b0;
      sda1_oe_out <= 1'b0;
    end else begin
      scl0_oe_out <= stall_reg & ~cfg_reg[`ISS_CFG_PINSEL]; // R1
      sda0_oe_out <= sda_low_reg & ~cfg_reg[`ISS_CFG_PINSEL];
      scl1_oe_out <= stall_reg & cfg_reg[`ISS_CFG_PINSEL];
      sda1_oe_out <= sda_low_reg & cfg_reg[`ISS_CFG_PINSEL];
    end
  end
endmodule // iss_top

/* shared/iss_consts.vh */
`ifndef ISS_CONSTS_VH
`define ISS_CONSTS_VH
// register offsets (byte addresses, one word each)
`define ISS_OFF_CFG 8'h00
`define ISS_OFF_ADDR 8'h04
`define ISS_OFF_CSR 8'h08
`define ISS_OFF_DATA 8'h0c
`define ISS_OFF_IRQ_STAT 8'h10
`define ISS_OFF_IRQ_MASK 8'h14
// configuration register fields
`define ISS_CFG_EN 0
`define ISS_CFG_PINSEL 1
`define ISS_CFG_RATE_LO 2
`define ISS_CFG_RATE_HI 3
`define ISS_CFG_POLLED 4
`define ISS_CFG_INTEN 5
`define ISS_CFG_W 6
// bus rate codes
`define ISS_RATE_50K 2'h0
`define ISS_RATE_100K 2'h1
`define ISS_RATE_400K 2'h2
// control/status write field
`define ISS_CSR_NAK 0
// irq status fields
`define ISS_IRQ_BYTE 0
`define ISS_IRQ_STOP 1
`define ISS_IRQ_ERR 2
`define ISS_IRQ_W 3
// reset values
`define ISS_CFG_RST 6'h00
`define ISS_ADDR_RST 7'h00
`define ISS_MASK_RST 3'h0
// data setup before releasing the clock line, in 50 MHz core cycles
// (1000 ns, 500 ns and 100 ns for the three rates)
`define ISS_TSU_50K_CYC 8'h32
`define ISS_TSU_100K_CYC 8'h19
`define ISS_TSU_400K_CYC 8'h05
`endif

/* tb/iss_chk.sv */
`timescale 1ns/1ps
`include "iss_consts.vh"
module iss_chk (
  input wire core_clk_in,
  input wire nrst_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rdata_out,
  input wire scl0_in,
  input wire scl0_oe_out,
  input wire sda0_oe_out,
  input wire scl1_in,
  input wire scl1_oe_out,
  input wire sda1_oe_out,
  input wire irq_out
);
  reg [7:0] cfg_reg; // shadow of config writes
  reg [7:0] msk_reg; // shadow of mask writes
  reg [7:0] gap_reg; // cycles since last status write, saturates
  wire any_oe = scl0_oe_out | sda0_oe_out | scl1_oe_out | sda1_oe_out;
  // setup cycles per rate; release may trail by a few pipeline stages
  wire [7:0] tsu = cfg_reg[3:2] == `ISS_RATE_50K ? 8'h32 :
    (cfg_reg[3:2] == `ISS_RATE_100K ? 8'h19 : 8'h05);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  // shadows let the rules refer to software settings
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      cfg_reg <= 8'h00;
      msk_reg <= 8'h00;
      gap_reg <= 8'hff;
    end else begin
      if (wr_in && addr_in == `ISS_OFF_CFG) cfg_reg <= wdata_in;
      if (wr_in && addr_in == `ISS_OFF_IRQ_MASK) msk_reg <= wdata_in;
      if (wr_in && addr_in == `ISS_OFF_CSR) gap_reg <= 8'h00;
      else if (gap_reg != 8'hff) gap_reg <= gap_reg + 8'h01;
    end
  end
  chk_pair0_only: assert property (!cfg_reg[1] |-> !(scl1_oe_out || sda1_oe_out))
    else $error("pair 1 driven");
  chk_pair1_only: assert property (cfg_reg[1] |-> !(scl0_oe_out || sda0_oe_out))
    else $error("pair 0 driven");
  chk_rdata_gap: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside slot");
  chk_mask_quiet: assert property (msk_reg == 8'h00 && $past(msk_reg) == 8'h00 |-> !irq_out)
    else $error("irq while masked");
  chk_off_quiet: assert property (!cfg_reg[0] && !$past(cfg_reg[0]) && !$past(cfg_reg[0], 2) |-> !any_oe)
    else $error("bus driven while off");
  // setup only matters while the slave pulls data; a bare release may come at once
  chk_stall_release: assert property ($fell(scl0_oe_out || scl1_oe_out) &&
    (sda0_oe_out || sda1_oe_out) |-> gap_reg >= tsu && gap_reg <= tsu + 8'h08)
    else $error("stall released off time");
  chk_release_bound: assert property ($fell(scl0_oe_out || scl1_oe_out) |->
    gap_reg <= tsu + 8'h08) else $error("stall released late");
  chk_sda0_low_clk: assert property ($changed(sda0_oe_out) |-> !scl0_in)
    else $error("data moved with clock high");
  chk_sda1_low_clk: assert property ($changed(sda1_oe_out) |-> !scl1_in)
    else $error("data moved with clock high");
  cover property ($rose(scl0_oe_out));
  cover property ($rose(scl1_oe_out));
  cover property ($rose(irq_out));
endmodule // iss_chk

/* tb/iss_master_model.sv */
`timescale 1ns/1ps
module iss_master_model (
  input wire scl_in,
  input wire sda_in,
  output logic scl_low_out,
  output logic sda_low_out
);
  int stall_to = 0; // clock never came back
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end
  // release the clock and wait out a stall, bounded
  task automatic rise();
    int n;
    scl_low_out = 1'b0;
    n = 0;
    while (scl_in !== 1'b1 && n < 30000) begin
      #10 n++;
    end
    if (n == 30000) stall_to++;
  endtask
  // 160 ns bit: long low phase leaves the slave time to turn data round
  task automatic bit_io(input logic b, output logic s);
    #20 sda_low_out = !b;
    #80 rise();
    #30 s = sda_in;
    #30 scl_low_out = 1'b1;
  endtask
  // msb first; ack_in high leaves data free for the slave
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
    output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack);
  endtask
  task automatic start();
    #100 sda_low_out = 1'b1;
    #100 scl_low_out = 1'b1;
  endtask
  task automatic stop();
    #20 sda_low_out = 1'b1;
    #80 rise();
    #100 sda_low_out = 1'b0;
    #100;
  endtask
endmodule // iss_master_model

/* tb/tb_iss_top.sv */
`timescale 1ns/1ps
`include "iss_consts.vh"
module tb_iss_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0; // a read was launched last cycle
  logic psel = 1'b0; // pin pair the master sits on
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];
  logic [6:0] own;
  logic [7:0] d0, d1, r0, r1;
  logic a0, a1, a2, ib;
  int fail_count = 0;
  int samples_checked = 0;
  int seed = 32'h0c4ff74d;
  wire m_scl, m_sda, scl0_oe, sda0_oe, scl1_oe, sda1_oe, irq;
  wire [7:0] rdata;
  // open drain with pull-ups; the unused pair idles high
  wire scl0 = !((m_scl && !psel) || scl0_oe);
  wire sda0 = !((m_sda && !psel) || sda0_oe);
  wire scl1 = !((m_scl && psel) || scl1_oe);
  wire sda1 = !((m_sda && psel) || sda1_oe);
  iss_top iss_top_i (.core_clk_in(clk), .nrst_in(nrst), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .scl0_in(scl0), .scl0_out(),
    .scl0_oe_out(scl0_oe), .sda0_in(sda0), .sda0_out(), .sda0_oe_out(sda0_oe),
    .scl1_in(scl1), .scl1_out(), .scl1_oe_out(scl1_oe), .sda1_in(sda1), .sda1_out(),
    .sda1_oe_out(sda1_oe), .irq_out(irq));
  iss_master_model iss_master_model_i (.scl_in(psel ? scl1 : scl0),
    .sda_in(psel ? sda1 : sda0), .scl_low_out(m_scl), .sda_low_out(m_sda));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_q) check(rdata & msk_q.pop_front(), exp_q.pop_front());
    rd_q <= rd;
  end
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  // one service action: wait for the event, inspect, answer, see the stall go
  task automatic service(input logic [7:0] ie, ce, cm, de, dm, tx, input logic nak);
    int n;
    n = 0;
    while ({irq, scl0_oe, scl1_oe} === 3'b000 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (n == 20000) fail_count++;
    if (n == 20000) tally_and_finish();
    rd_chk(`ISS_OFF_IRQ_STAT, ie, 8'hff);
    rd_chk(`ISS_OFF_CSR, ce, cm);
    rd_chk(`ISS_OFF_DATA, de, dm);
    if (ce[0]) check({7'h00, psel ? scl1 : scl0}, 8'h00);
    reg_wr(`ISS_OFF_DATA, tx);
    reg_wr(`ISS_OFF_CSR, {7'h00, nak});
    n = 0;
    while (ce[0] && {scl0_oe, scl1_oe} !== 2'b00 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n == 200) fail_count++;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd_chk(`ISS_OFF_CFG, 8'h00, 8'hff);
    rd_chk(`ISS_OFF_ADDR, 8'h00, 8'hff);
    rd_chk(8'h18, 8'h00, 8'hff);
    reg_wr(`ISS_OFF_IRQ_MASK, 8'h07);
    // master writes at each rate; pair 1 runs polled
    for (int r = 0; r < 3; r++) begin
      psel = (r == 1);
      ib = (r != 1);
      own = $random(seed);
      d0 = $random(seed);
      d1 = $random(seed);
      reg_wr(`ISS_OFF_ADDR, {1'b0, own});
      reg_wr(`ISS_OFF_CFG, {2'b00, 1'b1, psel, r[1:0], psel, 1'b1});
      fork
        begin
          iss_master_model_i.start();
          iss_master_model_i.xfer({own, 1'b0}, 1'b1, r0, a0);
          iss_master_model_i.xfer(d0, 1'b1, r0, a1);
          iss_master_model_i.xfer(d1, 1'b1, r0, a2);
          iss_master_model_i.stop();
        end
        begin
          service({7'h00, ib}, 8'h05, 8'h37, {own, 1'b0}, 8'hff, 8'h00, 1'b0);
          service({7'h00, ib}, 8'h01, 8'h37, d0, 8'hff, 8'h00, 1'b0);
          service({7'h00, ib}, 8'h01, 8'h37, d1, 8'hff, 8'h00, 1'b1);
          service(8'h02, 8'h10, 8'h31, 8'h00, 8'h00, 8'h00, 1'b0);
        end
      join
      check({5'h00, a0, a1, a2}, 8'h01);
    end
    // master reads two bytes, acking the first only
    psel = 1'b0;
    d0 = $random(seed);
    d1 = $random(seed);
    reg_wr(`ISS_OFF_CFG, 8'h29);
    fork
      begin
        iss_master_model_i.start();
        iss_master_model_i.xfer({own, 1'b1}, 1'b1, r0, a0);
        iss_master_model_i.xfer(8'hff, 1'b0, r0, a1);
        iss_master_model_i.xfer(8'hff, 1'b1, r1, a2);
        iss_master_model_i.stop();
      end
      begin
        service(8'h01, 8'h07, 8'h37, {own, 1'b1}, 8'hff, d0, 1'b0);
        service(8'h01, 8'h0b, 8'h3f, 8'h00, 8'h00, d1, 1'b0);
        service(8'h01, 8'h03, 8'h3f, 8'h00, 8'h00, d1, 1'b0);
      end
    join
    check(r0, d0);
    check(r1, d1);
    // the stop after a refused read byte closes quietly, nothing left pending
    rd_chk(`ISS_OFF_IRQ_STAT, 8'h00, 8'hff);
    rd_chk(`ISS_OFF_CSR, 8'h02, 8'h7f);
    // foreign address, slave off, interrupt off: all ignored
    for (int c = 0; c < 3; c++) begin
      reg_wr(`ISS_OFF_CFG, c == 1 ? 8'h20 : (c == 2 ? 8'h01 : 8'h21));
      iss_master_model_i.start();
      iss_master_model_i.xfer({own ^ {6'h00, c == 0}, 1'b0}, 1'b1, r0, a0);
      iss_master_model_i.xfer(d0, 1'b1, r0, a1);
      iss_master_model_i.stop();
      check({6'h00, a0, a1}, 8'h03);
      rd_chk(`ISS_OFF_IRQ_STAT, 8'h00, 8'hff);
    end
    check({7'h00, iss_master_model_i.stall_to != 0}, 8'h00);
    tally_and_finish();
  end
endmodule // tb_iss_top
bind iss_top iss_chk iss_chk_i (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .scl0_in(scl0_in), .scl0_oe_out(scl0_oe_out),
  .sda0_oe_out(sda0_oe_out), .scl1_in(scl1_in), .scl1_oe_out(scl1_oe_out),
  .sda1_oe_out(sda1_oe_out), .irq_out(irq_out));
